// File: rtl/fmhp_defs.svh
`ifndef FMHP_DEFS_SVH
`define FMHP_DEFS_SVH

// Port widths
`define FMHP_ADDR_W        7
`define FMHP_DATA_W        8
`define FMHP_TEST_W        3
// Factory test value for normal operation
`define FMHP_TEST_NORMAL   3'h0
// Interface style strap values
`define FMHP_STYLE_SPLIT   1'h1
`define FMHP_STYLE_DSRW    1'h0
// Clock rate and reset pulse
`define FMHP_CLK_MHZ       50
`define FMHP_RESET_NS      1000
`define FMHP_RESET_CYC     ((`FMHP_RESET_NS * `FMHP_CLK_MHZ + 999) / 1000)
// Read data latency in clock cycles before completion
`define FMHP_READ_WAIT     2

`endif

// File: rtl/fmhp_pkg.sv
package fmhp_pkg;
  typedef enum logic [2:0] {
    IDLE,
    WAIT_RD,
    WRITE,
    DONE,
    RELEASE
  } fmhp_state_e;

  // Synchronised host control pins
  typedef struct packed {
    logic       csN;
    logic       strobeN;
    logic       rwLevel;
    logic       style;
    logic [2:0] test;
    logic [6:0] addr;
    logic [7:0] wdata;
  } fmhp_ctl_s;

  // Register-side access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } fmhp_req_s;

  // Full module state
  typedef struct packed {
    fmhp_ctl_s   s1;
    fmhp_ctl_s   s2;
    fmhp_state_e state;
    logic [1:0]  waitCnt;
    logic [6:0]  addr;
    logic [7:0]  rdData;
    fmhp_req_s   req;
    logic        dataOe;
    logic        doneN;
    logic        doneOe;
    logic        intN;
    logic        testMode;
    logic [1:0]  intS;
  } fmhp_state_s;
endpackage

// File: rtl/fmhp_host_port.sv
`timescale 1ns/1ps
`include "fmhp_defs.svh"
module fmhp_host_port
  import fmhp_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      interfaceStyleSelect,
  input  wire logic                      chipSelectN,
  input  wire logic                      dataStrobeN,
  input  wire logic                      rwLevel,
  input  wire logic [`FMHP_ADDR_W-1:0]   registerAddressBus,
  input  wire logic [`FMHP_DATA_W-1:0]   registerDataIn,
  output logic      [`FMHP_DATA_W-1:0]   registerDataOut,
  output logic                           registerDataOe,
  output logic                           completionN,
  output logic                           completionOe,
  input  wire logic                      interruptSource,
  output logic                           hostInterruptN,
  input  wire logic [`FMHP_TEST_W-1:0]   factoryTestSelect,
  output logic                           testModeActive,
  output logic                           regRead,
  output logic                           regWrite,
  output logic      [`FMHP_ADDR_W-1:0]   regAddr,
  output logic      [`FMHP_DATA_W-1:0]   regWriteData,
  input  wire logic [`FMHP_DATA_W-1:0]   regReadData
);

  fmhp_state_s st_r;
  fmhp_state_s st_nxt;
  logic        selected;
  logic        isRead;
  logic        isWrite;
  logic        bothStrobes;

  // Shared strobe pins decoded per strap style; the strap is read only
  // after its own synchroniser, so a strap moved under power settles
  // before it can steer a half-seen access
  always_comb begin
    selected    = !st_r.s2.csN;
    isRead      = 1'h0;
    isWrite     = 1'h0;
    if (st_r.s2.style == `FMHP_STYLE_SPLIT) begin
      // Split style: read strobe on strobe pin, write strobe on level pin
      isRead  = selected && !st_r.s2.strobeN;
      isWrite = selected && !st_r.s2.rwLevel;
    end else begin
      // Strobe-and-level style: one strobe, direction from the level
      isRead  = selected && !st_r.s2.strobeN && st_r.s2.rwLevel;
      isWrite = selected && !st_r.s2.strobeN && !st_r.s2.rwLevel;
    end
    // Both strobes at once has no meaning, so it is refused
    bothStrobes = isRead && isWrite;
  end

  // Next-state logic, one copy of the whole state
  always_comb begin
    st_nxt            = st_r;

    // Pin synchronisers: host pins, strap and test pins pass two flops;
    // address and data ride along with the strobes, so the word sampled
    // always belongs to the strobe that qualifies it
    st_nxt.s1.csN     = chipSelectN;
    st_nxt.s1.strobeN = dataStrobeN;
    st_nxt.s1.rwLevel = rwLevel;
    st_nxt.s1.style   = interfaceStyleSelect;
    st_nxt.s1.test    = factoryTestSelect;
    st_nxt.s1.addr    = registerAddressBus;
    st_nxt.s1.wdata   = registerDataIn;
    st_nxt.s2         = st_r.s1;

    // Interrupt level passes two flops, then pulls the pin low
    st_nxt.intS       = {st_r.intS[0], interruptSource};
    st_nxt.intN       = !st_r.intS[1];

    // Any nonzero test code leaves normal operation
    st_nxt.testMode   = (st_r.s2.test != `FMHP_TEST_NORMAL);

    // Register-side strobes are single-cycle pulses
    st_nxt.req.rd     = 1'h0;
    st_nxt.req.wr     = 1'h0;

    unique case (st_r.state)
      IDLE: begin
        // Accept one direction only; both strobes together is refused
        if (isRead && !bothStrobes) begin
          st_nxt.addr     = st_r.s2.addr;
          st_nxt.req.addr = st_r.s2.addr;
          st_nxt.req.rd   = 1'h1;
          st_nxt.waitCnt  = 2'h0;
          st_nxt.state    = WAIT_RD;
        end else if (isWrite && !bothStrobes) begin
          // Write data taken here, one cycle before completion is shown
          st_nxt.req.addr  = st_r.s2.addr;
          st_nxt.req.wdata = st_r.s2.wdata;
          st_nxt.req.wr    = 1'h1;
          st_nxt.state     = WRITE;
        end
      end

      WAIT_RD: begin
        if (!selected) begin
          // Host gave up mid-read: free the pins, never show completion
          st_nxt.dataOe = 1'h0;
          st_nxt.doneOe = 1'h0;
          st_nxt.state  = RELEASE;
        end else begin
          // Register file answers in the same cycle as the request pulse
          if (st_r.waitCnt == 2'h0) begin
            st_nxt.rdData = regReadData;
          end
          // Data goes out a cycle ahead of completion for setup margin
          st_nxt.dataOe  = 1'h1;
          st_nxt.doneOe  = 1'h1;
          st_nxt.waitCnt = st_r.waitCnt + 2'h1;
          if (st_r.waitCnt == 2'(`FMHP_READ_WAIT - 1)) begin
            st_nxt.doneN = 1'h0;
            st_nxt.state = DONE;
          end
        end
      end

      WRITE: begin
        // Write already latched, so completion may follow at once;
        // a host that dropped select meanwhile gets no completion
        if (selected) begin
          st_nxt.doneOe = 1'h1;
          st_nxt.doneN  = 1'h0;
          st_nxt.state  = DONE;
        end else begin
          st_nxt.state  = RELEASE;
        end
      end

      DONE: begin
        // Hold completion until the strobe or select goes away
        if (!(isRead || isWrite)) begin
          st_nxt.doneN = 1'h1;
          st_nxt.state = RELEASE;
        end
      end

      RELEASE: begin
        // Data driver off and completion driven inactive before the next access can be taken
        st_nxt.dataOe = 1'h0;
        st_nxt.doneN  = 1'h1;
        st_nxt.state  = IDLE;
      end
    endcase

    // Deselect frees both three-state pins together; completion goes
    // inactive in the same cycle so an undriven pin never reads as done
    if (!selected) begin
      st_nxt.dataOe = 1'h0;
      st_nxt.doneOe = 1'h0;
      st_nxt.doneN  = 1'h1;
    end
  end

  // State register; reset loads the synchronisers with fixed idle levels,
  // strap as strobe-and-level style, whatever the pins show as reset lifts
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r <= '{s1: '{csN: 1'h1, strobeN: 1'h1, rwLevel: 1'h1, style: 1'h0,
                      test: 3'h0, addr: 7'h00, wdata: 8'h00},
                s2: '{csN: 1'h1, strobeN: 1'h1, rwLevel: 1'h1, style: 1'h0,
                      test: 3'h0, addr: 7'h00, wdata: 8'h00},
                state: IDLE,
                waitCnt: 2'h0,
                addr: 7'h00,
                rdData: 8'h00,
                req: '0,
                dataOe: 1'h0,
                doneN: 1'h1,
                doneOe: 1'h0,
                intN: 1'h1,
                testMode: 1'h0,
                intS: 2'h0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Host-side pins, all straight from the state register
  assign registerDataOut = st_r.rdData;
  assign registerDataOe  = st_r.dataOe;
  assign completionN     = st_r.doneN;
  assign completionOe    = st_r.doneOe;
  assign hostInterruptN  = st_r.intN;
  assign testModeActive  = st_r.testMode;

  // Register-file side; address and data stay put after the pulse
  assign regRead         = st_r.req.rd;
  assign regWrite        = st_r.req.wr;
  assign regAddr         = st_r.req.addr;
  assign regWriteData    = st_r.req.wdata;

endmodule

// File: bench/fmhp_properties.sv
`timescale 1ns/1ps
module fmhp_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic chipSelectN,
  input wire logic registerDataOe,
  input wire logic completionN,
  input wire logic completionOe,
  input wire logic regRead,
  input wire logic regWrite
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Select idle long enough to clear the sync stages
  sequence s_idle; chipSelectN[*5]; endsequence
  property p_rd; regRead |-> ##[1:3] (!completionN && completionOe && registerDataOe); endproperty
  a_rd: assert property (p_rd) else $error("read ack late");
  property p_wr; regWrite |-> !registerDataOe ##[0:2] !completionN; endproperty
  a_wr: assert property (p_wr) else $error("write ack late");
  property p_rel; s_idle |-> !completionOe && !registerDataOe; endproperty
  a_rel: assert property (p_rel) else $error("pins held");
  property p_ign; s_idle |-> !regRead && !regWrite; endproperty
  a_ign: assert property (p_ign) else $error("deselected access");
  property p_one; !(regRead && regWrite); endproperty
  a_one: assert property (p_one) else $error("read and write");
  property p_oe; !completionN |-> completionOe; endproperty
  a_oe: assert property (p_oe) else $error("ack undriven");
  property p_sel; (regRead || regWrite) |-> !$past(chipSelectN, 3); endproperty
  a_sel: assert property (p_sel) else $error("access unselected");
  property p_pls; regWrite |=> !regWrite; endproperty
  a_pls: assert property (p_pls) else $error("double write");
endmodule

bind fmhp_host_port fmhp_properties u_props (.clock(clock), .rstn(rstn), .chipSelectN(chipSelectN),
  .registerDataOe(registerDataOe), .completionN(completionN), .completionOe(completionOe),
  .regRead(regRead), .regWrite(regWrite));

// File: bench/fmhp_host_model.sv
`timescale 1ns/1ps
module fmhp_host_model (
  input  wire logic       clock,
  input  wire logic       completionN,
  input  wire logic [7:0] dataBus,
  output logic            chipSelectN,
  output logic            dataStrobeN,
  output logic            rwLevel,
  output logic      [6:0] addr,
  output logic      [7:0] wdata
);
  initial {chipSelectN, dataStrobeN, rwLevel, addr, wdata} = 18'h38000;
  // One access; pins held until the edge that sees completion, or for at most 12 edges
  task automatic xfer(input logic split, rd, csN, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    @(posedge clock) #1;
    chipSelectN = csN;
    addr = a;
    wdata = d;
    rwLevel = rd;
    dataStrobeN = split & !rd;
    ok = 1'b0;
    for (int n = 0; n < 12 && !ok; n++) begin
      @(posedge clock);
      ok = (completionN === 1'b0);
    end
    q = dataBus;
    #1;
    {chipSelectN, dataStrobeN, rwLevel} = 3'h7;
    wdata = ~d; // Released bus must not show stale data
    repeat (5) @(posedge clock);
  endtask
endmodule

// File: bench/fmhp_tb.sv
`timescale 1ns/1ps
`include "fmhp_defs.svh"
module tb;
  logic       clock = 1'b0, rstn = 1'b0, style = 1'b0, intSrc = 1'b0;
  logic [2:0] testSel = 3'h0;
  logic       csN, dsN, rw, dOe, cN, cOe, intN, tMode, rd, wr, ok;
  logic [6:0] addr, rAddr;
  logic [7:0] wdata, dOut, rWData, q, mem [128];
  int         badCount = 0, checkCount = 0, cyc = 0;
  fmhp_host_port u_dut (.clock(clock), .rstn(rstn), .interfaceStyleSelect(style), .chipSelectN(csN),
    .dataStrobeN(dsN), .rwLevel(rw), .registerAddressBus(addr), .registerDataIn(dOe ? dOut : wdata),
    .registerDataOut(dOut), .registerDataOe(dOe), .completionN(cN), .completionOe(cOe),
    .interruptSource(intSrc), .hostInterruptN(intN), .factoryTestSelect(testSel), .testModeActive(tMode),
    .regRead(rd), .regWrite(wr), .regAddr(rAddr), .regWriteData(rWData), .regReadData(mem[rAddr]));
  fmhp_host_model u_host (.clock(clock), .completionN(cOe ? cN : 1'b1), .dataBus(dOe ? dOut : wdata),
    .chipSelectN(csN), .dataStrobeN(dsN), .rwLevel(rw), .addr(addr), .wdata(wdata));
  // Register file stand-in; completion pin pulled up when undriven
  always @(posedge clock) if (wr) mem[rAddr] <= rWData;
  initial forever #10 clock = ~clock;
  // Cycle ceiling cuts a hung handshake short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      badCount++;
      reportAndStop();
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, got);
    checkCount++;
    if (exp !== got) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reportAndStop();
    if (badCount == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Write then read back in one strap style
  task automatic t_access(input logic s, input logic [6:0] a, input logic [7:0] d);
    @(posedge clock) #1 style = s;
    u_host.xfer(s, 1'b0, 1'b0, a, d, q, ok);
    chk("wr ack", 8'h01, {7'h0, ok});
    chk("stored", d, mem[a]);
    u_host.xfer(s, 1'b1, 1'b0, a, 8'h00, q, ok);
    chk("rd ack", 8'h01, {7'h0, ok});
    chk("rd data", d, q);
    chk("reg addr", {1'b0, a}, {1'b0, rAddr});
    chk("data oe off", 8'h00, {7'h0, dOe});
    chk("ack oe off", 8'h00, {7'h0, cOe});
  endtask
  // Write strobe with select high must change nothing
  task automatic t_refuse();
    u_host.xfer(1'b1, 1'b0, 1'b1, 7'h7F, 8'h00, q, ok);
    chk("refused", 8'h00, {7'h0, ok});
    chk("kept", 8'hC3, mem[7'h7F]);
  endtask
  // Interrupt follows its source; test pins select test mode
  task automatic t_misc();
    #1 intSrc = 1'b1;
    repeat (6) @(posedge clock);
    chk("irq", 8'h00, {7'h0, intN});
    #1 intSrc = 1'b0;
    testSel = 3'h5;
    repeat (6) @(posedge clock);
    chk("irq off", 8'h01, {7'h0, intN});
    chk("test", 8'h01, {7'h0, tMode});
    #1 testSel = `FMHP_TEST_NORMAL;
    repeat (6) @(posedge clock);
    chk("normal", 8'h00, {7'h0, tMode});
  endtask
  initial begin
    repeat (`FMHP_RESET_CYC) @(posedge clock);
    #1 rstn = 1'b1;
    t_access(1'b0, 7'h00, 8'hA5);
    t_access(1'b1, 7'h7F, 8'hC3);
    t_refuse();
    t_misc();
    reportAndStop();
  end
endmodule
